// ---- shared/rwseq_pkg.sv ----
// Purpose: Constants and types shared by the reset and warm-up sequencer
// Assumes: 40 MHz system clock, one clock domain
// Notes:   Register offsets are word indexes on the plain register port
package rwseq_pkg;

  // Register map (index on the register port)
  localparam logic [3:0] RWSEQ_REG_CTRL    = 4'h0;
  localparam logic [3:0] RWSEQ_REG_WARMUP  = 4'h1;
  localparam logic [3:0] RWSEQ_REG_STATUS  = 4'h2;
  localparam logic [3:0] RWSEQ_REG_CAUSE   = 4'h3;
  localparam logic [3:0] RWSEQ_REG_TRIM    = 4'h4;
  localparam logic [3:0] RWSEQ_REG_CORE    = 4'h5;

  // Widths
  localparam int RWSEQ_CNT_W  = 16;
  localparam int RWSEQ_TRIM_W = 8;
  localparam int RWSEQ_TADR_W = 3;

  // Reset values
  localparam logic [15:0] RWSEQ_PC_MCU     = 16'hFFFE;
  localparam logic [15:0] RWSEQ_PC_PROM    = 16'h1FFE;
  localparam logic [15:0] RWSEQ_SP_RESET   = 16'h00FF;
  localparam logic [15:0] RWSEQ_VEC_LO     = 16'hFFFE;
  localparam logic [15:0] RWSEQ_VEC_HI     = 16'hFFFF;
  localparam logic [15:0] RWSEQ_WARMUP_DEF = 16'h0400;
  localparam logic [15:0] RWSEQ_WARMUP_MIN = 16'h0010;

  // Trim store: words 0..RWSEQ_TRIM_LAST, last word is a checksum byte
  localparam logic [RWSEQ_TADR_W-1:0] RWSEQ_TRIM_LAST = 3'h3;

  // Status and control field positions
  localparam int RWSEQ_ST_RUN     = 0;
  localparam int RWSEQ_ST_WARM    = 1;
  localparam int RWSEQ_ST_TRMBAD  = 2;
  localparam int RWSEQ_ST_VDET    = 3;
  localparam int RWSEQ_CT_TRCLR   = 0;
  localparam int RWSEQ_CT_VDETEN  = 1;

  // Cause bits
  localparam int RWSEQ_CA_POR  = 0;
  localparam int RWSEQ_CA_PIN  = 1;
  localparam int RWSEQ_CA_INT  = 2;

  // Sequencer states
  typedef enum logic [3:0] {
    RWSEQ_ST_RESET  = 4'b0001,
    RWSEQ_ST_WARMUP = 4'b0010,
    RWSEQ_ST_FETCH  = 4'b0100,
    RWSEQ_ST_RUNS   = 4'b1000
  } rwseq_state_type;

  // Reset sources after synchronising
  typedef struct packed {
    logic por;
    logic pin;
    logic internal;
  } rwseq_src_type;

  // Core-facing reset state
  typedef struct packed {
    logic [15:0] program_counter;
    logic [15:0] stack_pointer;
    logic [1:0]  register_bank_select;
    logic        interrupt_master_enable;
    logic        core_reset;
    logic        periph_reset;
  } rwseq_core_type;

  // Oscillator, timing block, watchdog and port controls
  typedef struct packed {
    logic int_osc_en;
    logic ext_hf_osc_en;
    logic ext_lf_osc_en;
    logic tg_clear;
    logic wdt_en;
    logic port_hiz;
  } rwseq_sys_type;

endpackage

// ---- rtl/rwseq_sync.sv ----
// Purpose: Three-stage synchroniser with agreement filter for reset pins
// Assumes: Input is asynchronous to clk_in
// Notes:   Output changes only when stages two and three agree
`timescale 1ns/1ps
module rwseq_sync (
  // Clock and reset
  input  wire logic clk_in,
  input  wire logic rstn_in,
  // Data
  input  wire logic async_in,
  output logic      sync_out
);
  logic s1;
  logic s2;
  logic s3;

  // First stage feeds only the second; output follows agreed level
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      s1       <= 1'b1;
      s2       <= 1'b1;
      s3       <= 1'b1;
      sync_out <= 1'b1;
    end else begin
      s1 <= async_in;
      s2 <= s1;
      s3 <= s2;
      if (s2 == s3) begin
        sync_out <= s3;
      end
    end
  end
endmodule // rwseq_sync

// ---- rtl/rwseq_trim.sv ----
// Purpose: Trim data loader run during warm-up
// Assumes: Trim store answers one cycle after the address is held
// Notes:   Checksum is a plain XOR of the data words
`timescale 1ns/1ps
module rwseq_trim
  import rwseq_pkg::*;
(
  // Clock and reset
  input  wire logic                    clk_in,
  input  wire logic                    rstn_in,
  // Control
  input  wire logic                    start_in,
  input  wire logic                    hold_in,
  output logic                         done_out,
  output logic                         bad_out,
  // Trim store
  output logic [RWSEQ_TADR_W-1:0]      addr_out,
  input  wire logic [RWSEQ_TRIM_W-1:0] data_in,
  // Latched trim
  output logic [RWSEQ_TRIM_W-1:0]      trim_out
);
  logic                    busy;
  logic                    wait_rd;
  logic [RWSEQ_TRIM_W-1:0] sum;
  wire                     last_w  = (addr_out == RWSEQ_TRIM_LAST);
  wire [RWSEQ_TRIM_W-1:0]  nsum_w  = sum ^ data_in;

  // Walks the store; a reset in progress abandons the load
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      busy <= 1'b0; wait_rd <= 1'b0; done_out <= 1'b0; bad_out <= 1'b0;
      addr_out <= '0; sum <= '0; trim_out <= '0;
    end else if (hold_in) begin
      busy <= 1'b0; wait_rd <= 1'b0; done_out <= 1'b0;
      addr_out <= '0; sum <= '0;
    end else if (start_in && !busy && !done_out) begin
      busy <= 1'b1; wait_rd <= 1'b1; addr_out <= '0; sum <= '0;
    end else if (busy && wait_rd) begin
      wait_rd <= 1'b0;
    end else if (busy) begin
      sum <= nsum_w;
      if (addr_out == '0) begin
        trim_out <= data_in;
      end
      if (last_w) begin
        busy     <= 1'b0;
        done_out <= 1'b1;
        bad_out  <= (nsum_w != '0);
      end else begin
        addr_out <= addr_out + 1'b1;
        wait_rd  <= 1'b1;
      end
    end
  end
endmodule // rwseq_trim

// ---- rtl/rwseq_top.sv ----
// Purpose: Merges reset sources, runs warm-up, then releases the core
// Assumes: 40 MHz clk_in; rstn_in is the raw power-on detector output
// Notes:   Register port gives software warm-up length and status view
`timescale 1ns/1ps

// Notes on behaviour
// - Power-on, pin and internal resets all feed the warm-up logic.
// - Any reset clears warm-up counter and holds core and peripherals.
// - Release starts the warm-up counter on the high-frequency clock.
// - Trim data loads from its store into latches during warm-up.
// - After warm-up the core fetches its vector from FFFE and FFFF.
// - A reset during warm-up clears the counter and restarts later.
// - Program counter FFFE or 1FFE by mode; stack pointer 00FF.
// - Bank select, master enable, enables and latches clear to zero.
// - Internal oscillator on, both external oscillators off in reset.
// - Prescaler and divider held at zero through reset and warm-up.
// - Only power-on or pin reset disables voltage detection.
// - All sources act alike except voltage detection, warm-up length, trim-abnormal flag and cause bits.
// - Power-on reset holds while supply is low, then releases.
// - Power-on reset asserts when supply falls below threshold.
// - Power-on and pin reset are ORed together.
// - Abnormal trim data sets the trim-abnormal flag to one.
module rwseq_top
  import rwseq_pkg::*;
(
  // Clock and power-on reset
  input  wire logic                    clk_in,
  input  wire logic                    rstn_in,
  // Other reset sources and boot mode select
  input  wire logic                    pin_rstn_in,
  input  wire logic                    int_rst_in,
  input  wire logic                    prom_mode_in,
  // Register port
  input  wire logic [3:0]              reg_addr_in,
  input  wire logic [15:0]             reg_wdata_in,
  input  wire logic                    reg_wr_in,
  input  wire logic                    reg_rd_in,
  output logic [15:0]                  reg_rdata_out,
  // Trim store
  output logic [RWSEQ_TADR_W-1:0]      trim_addr_out,
  input  wire logic [RWSEQ_TRIM_W-1:0] trim_data_in,
  output logic [RWSEQ_TRIM_W-1:0]      trim_latch_out,
  output logic                         trim_data_abnormal_flag_out,
  // Core and system controls
  output rwseq_core_type               core_out,
  output logic [15:0]                  vector_addr_out,
  output logic                         vector_rd_out,
  output logic [7:0]                   interrupt_enable_bits_out,
  output logic [7:0]                   interrupt_latches_out,
  output rwseq_sys_type                sys_out,
  output logic                         vdet_en_out
);

  rwseq_state_type          state;
  rwseq_state_type          next_state;
  rwseq_src_type            src;
  logic                     pin_sync;
  logic                     int_sync;
  logic [RWSEQ_CNT_W-1:0]   warm_cnt;
  logic [RWSEQ_CNT_W-1:0]   warm_limit;
  logic                     vdet_en;
  logic                     trim_bad;
  logic [2:0]               cause;
  logic                     fetch_hi;
  logic                     trim_done;
  logic                     trim_bad_raw;
  logic [RWSEQ_TRIM_W-1:0]  trim_val;
  logic [RWSEQ_TADR_W-1:0]  trim_addr;

  // Pin and internal requests are synchronised; the power-on line is the
  // asynchronous reset itself, so it follows the supply directly
  rwseq_sync u_pin_sync (
    .clk_in   (clk_in),
    .rstn_in  (rstn_in),
    .async_in (pin_rstn_in),
    .sync_out (pin_sync)
  );

  rwseq_sync u_int_sync (
    .clk_in   (clk_in),
    .rstn_in  (rstn_in),
    .async_in (!int_rst_in),
    .sync_out (int_sync)
  );

  // Source merge: power-on ORed with pin, internal factors added
  assign src.por      = 1'b0;               // Covered by rstn_in
  assign src.pin      = !pin_sync;
  assign src.internal = !int_sync;
  wire any_rst_w      = src.por | src.pin | src.internal;
  wire hard_rst_w     = src.por | src.pin;

  // Decode of register port
  wire wr_ctrl_w   = reg_wr_in && (reg_addr_in == RWSEQ_REG_CTRL);
  wire wr_warm_w   = reg_wr_in && (reg_addr_in == RWSEQ_REG_WARMUP);
  wire run_w       = (state == RWSEQ_ST_RUNS);
  wire trclr_w     = wr_ctrl_w && reg_wdata_in[RWSEQ_CT_TRCLR] && run_w;
  wire warm_end_w  = (warm_cnt >= warm_limit) && trim_done;
  wire [15:0] pc_w = prom_mode_in ? RWSEQ_PC_PROM : RWSEQ_PC_MCU;

  // Trim loader runs only inside warm-up
  rwseq_trim u_trim (
    .clk_in   (clk_in),
    .rstn_in  (rstn_in),
    .start_in (state == RWSEQ_ST_WARMUP),
    .hold_in  (any_rst_w),
    .done_out (trim_done),
    .bad_out  (trim_bad_raw),
    .addr_out (trim_addr),
    .data_in  (trim_data_in),
    .trim_out (trim_val)
  );

  // Next state: any reset wins over every other move
  always_comb begin
    next_state = state;
    unique case (state)
      RWSEQ_ST_RESET: begin
        if (!any_rst_w) begin
          next_state = RWSEQ_ST_WARMUP;
        end
      end
      RWSEQ_ST_WARMUP: begin
        if (any_rst_w) begin
          next_state = RWSEQ_ST_RESET;
        end else if (warm_end_w) begin
          next_state = RWSEQ_ST_FETCH;
        end
      end
      RWSEQ_ST_FETCH: begin
        if (any_rst_w) begin
          next_state = RWSEQ_ST_RESET;
        end else if (fetch_hi) begin
          next_state = RWSEQ_ST_RUNS;
        end
      end
      RWSEQ_ST_RUNS: begin
        if (any_rst_w) begin
          next_state = RWSEQ_ST_RESET;
        end
      end
      default: next_state = RWSEQ_ST_RESET;
    endcase
  end

  // State register
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      state <= RWSEQ_ST_RESET;
    end else begin
      state <= next_state;
    end
  end

  // Warm-up counter: cleared in reset, counts, then freezes
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      warm_cnt <= '0;
    end else if (any_rst_w || state == RWSEQ_ST_RESET) begin
      warm_cnt <= '0;
    end else if (state == RWSEQ_ST_WARMUP && warm_cnt < warm_limit) begin
      warm_cnt <= warm_cnt + 1'b1;
    end
  end

  // Vector fetch: low byte address then high byte address
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      fetch_hi        <= 1'b0;
      vector_addr_out <= RWSEQ_VEC_LO;
      vector_rd_out   <= 1'b0;
    end else if (state == RWSEQ_ST_FETCH && !any_rst_w) begin
      fetch_hi        <= 1'b1;
      vector_addr_out <= fetch_hi ? RWSEQ_VEC_HI : RWSEQ_VEC_LO;
      vector_rd_out   <= 1'b1;
    end else begin
      fetch_hi        <= 1'b0;
      vector_addr_out <= RWSEQ_VEC_LO;
      vector_rd_out   <= 1'b0;
    end
  end

  // Warm-up length is software-held; a full reset restores the default
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      warm_limit <= RWSEQ_WARMUP_DEF;
    end else if (hard_rst_w) begin
      warm_limit <= RWSEQ_WARMUP_DEF;
    end else if (wr_warm_w && run_w) begin
      // Warm-up end also waits for trim_done; clamp too short a value
      warm_limit <= (reg_wdata_in < RWSEQ_WARMUP_MIN) ? RWSEQ_WARMUP_MIN
                                                      : reg_wdata_in;
    end
  end

  // Voltage detection enable: only hard resets clear it
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      vdet_en <= 1'b0;
    end else if (hard_rst_w) begin
      vdet_en <= 1'b0;
    end else if (wr_ctrl_w && run_w) begin
      vdet_en <= reg_wdata_in[RWSEQ_CT_VDETEN];
    end
  end

  // Trim-abnormal flag and reset cause; the set beats a software clear
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      trim_bad <= 1'b0;
      cause    <= 3'h1;                                   // Power-on
    end else begin
      if (trim_done && trim_bad_raw && state == RWSEQ_ST_WARMUP) begin
        trim_bad <= 1'b1;
      end else if (hard_rst_w || trclr_w) begin
        trim_bad <= 1'b0;
      end
      if (src.pin) begin
        cause <= 3'h2;
      end else if (src.internal) begin
        cause[RWSEQ_CA_INT] <= 1'b1;
      end else if (trclr_w) begin
        cause <= 3'h0;
      end
    end
  end

  // Core, interrupt and system outputs follow the state
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      core_out.program_counter         <= RWSEQ_PC_MCU;
      core_out.stack_pointer           <= RWSEQ_SP_RESET;
      core_out.register_bank_select    <= 2'h0;
      core_out.interrupt_master_enable <= 1'b0;
      core_out.core_reset              <= 1'b1;
      core_out.periph_reset            <= 1'b1;
      interrupt_enable_bits_out        <= 8'h00;
      interrupt_latches_out            <= 8'h00;
      sys_out                          <= 6'b100101;
    end else begin
      core_out.program_counter         <= pc_w;
      core_out.stack_pointer           <= RWSEQ_SP_RESET;
      core_out.register_bank_select    <= 2'h0;
      core_out.interrupt_master_enable <= 1'b0;
      core_out.core_reset              <= (next_state != RWSEQ_ST_RUNS);
      core_out.periph_reset            <= (next_state != RWSEQ_ST_RUNS);
      interrupt_enable_bits_out        <= 8'h00;
      interrupt_latches_out            <= 8'h00;
      sys_out.int_osc_en               <= 1'b1;
      sys_out.ext_hf_osc_en            <= 1'b0;
      sys_out.ext_lf_osc_en            <= 1'b0;
      sys_out.tg_clear                 <= (next_state != RWSEQ_ST_RUNS);
      sys_out.wdt_en                   <= (next_state == RWSEQ_ST_RUNS);
      sys_out.port_hiz                 <= (next_state != RWSEQ_ST_RUNS);
    end
  end

  // Read mux: one cycle of latency, unmapped reads give zero
  logic [15:0] rd_mux;
  always_comb begin
    unique case (reg_addr_in)
      RWSEQ_REG_CTRL:   rd_mux = {14'h0000, vdet_en, 1'b0};
      RWSEQ_REG_WARMUP: rd_mux = warm_limit;
      RWSEQ_REG_STATUS: rd_mux = {12'h000, vdet_en, trim_bad,
                                  state == RWSEQ_ST_WARMUP, run_w};
      RWSEQ_REG_CAUSE:  rd_mux = {13'h0000, cause};
      RWSEQ_REG_TRIM:   rd_mux = {8'h00, trim_val};
      RWSEQ_REG_CORE:   rd_mux = warm_cnt;
      default:          rd_mux = 16'h0000;
    endcase
  end

  // Read data and pass-through of latched values
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      reg_rdata_out               <= 16'h0000;
      trim_addr_out               <= '0;
      trim_latch_out              <= '0;
      trim_data_abnormal_flag_out <= 1'b0;
      vdet_en_out                 <= 1'b0;
    end else begin
      reg_rdata_out               <= reg_rd_in ? rd_mux : 16'h0000;
      trim_addr_out               <= trim_addr;
      trim_latch_out              <= trim_val;
      trim_data_abnormal_flag_out <= trim_bad;
      vdet_en_out                 <= vdet_en;
    end
  end

endmodule // rwseq_top

// ---- verification/rwseq_properties.sv ----
// Purpose: Port-level timing checks for the reset and warm-up sequencer
// Assumes: One clock domain, rstn_in asynchronous and active low
// Notes:   Sources are held many cycles, so sync delay is absorbed
`timescale 1ns/1ps
module rwseq_properties
  import rwseq_pkg::*;
(
  // Clock, reset sources and boot mode select
  input wire logic                    clk_in,
  input wire logic                    rstn_in,
  input wire logic                    pin_rstn_in,
  input wire logic                    int_rst_in,
  input wire logic                    prom_mode_in,
  // Register port
  input wire logic [3:0]              reg_addr_in,
  input wire logic [15:0]             reg_wdata_in,
  input wire logic                    reg_wr_in,
  input wire logic                    reg_rd_in,
  input wire logic [15:0]             reg_rdata_out,
  // Trim store
  input wire logic [RWSEQ_TADR_W-1:0] trim_addr_out,
  input wire logic [RWSEQ_TRIM_W-1:0] trim_data_in,
  input wire logic [RWSEQ_TRIM_W-1:0] trim_latch_out,
  input wire logic                    trim_data_abnormal_flag_out,
  // Core and system
  input wire rwseq_core_type          core_out,
  input wire logic [15:0]             vector_addr_out,
  input wire logic                    vector_rd_out,
  input wire logic [7:0]              interrupt_enable_bits_out,
  input wire logic [7:0]              interrupt_latches_out,
  input wire rwseq_sys_type           sys_out,
  input wire logic                    vdet_en_out
);
  logic [15:0] idle_cnt;

  default clocking @(posedge clk_in); endclocking
  default disable iff (!rstn_in);

  // Cycles with every source quiet; saturates so it never wraps
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) idle_cnt <= 16'h0000;
    else if (!pin_rstn_in || int_rst_in) idle_cnt <= 16'h0000;
    else if (idle_cnt != 16'hFFFF) idle_cnt <= idle_cnt + 16'h0001;
  end

  sequence s_lo; vector_rd_out && vector_addr_out == RWSEQ_VEC_LO; endsequence
  sequence s_hi; vector_rd_out && vector_addr_out == RWSEQ_VEC_HI; endsequence
  property p_vector; $rose(vector_rd_out) |-> s_lo ##1 s_hi ##1 !vector_rd_out; endproperty
  property p_release;
    $fell(core_out.core_reset) |->
      vector_rd_out && vector_addr_out == RWSEQ_VEC_HI && idle_cnt >= RWSEQ_WARMUP_MIN;
  endproperty
  property p_hold;
    (!pin_rstn_in || int_rst_in) [*6] |-> core_out.core_reset && core_out.periph_reset;
  endproperty
  property p_sp; core_out.core_reset |-> core_out.stack_pointer == RWSEQ_SP_RESET; endproperty
  property p_pc;
    core_out.core_reset && $past(rstn_in) && $stable(prom_mode_in) |->
      core_out.program_counter == (prom_mode_in ? RWSEQ_PC_PROM : RWSEQ_PC_MCU);
  endproperty
  property p_zero;
    core_out.register_bank_select == 2'h0 && !core_out.interrupt_master_enable &&
      interrupt_enable_bits_out == 8'h00 && interrupt_latches_out == 8'h00;
  endproperty
  property p_osc;
    core_out.core_reset |-> sys_out.int_osc_en && !sys_out.ext_hf_osc_en &&
      !sys_out.ext_lf_osc_en && sys_out.tg_clear && !sys_out.wdt_en && sys_out.port_hiz;
  endproperty
  property p_run;
    !core_out.core_reset |-> sys_out.wdt_en && !sys_out.tg_clear && !core_out.periph_reset;
  endproperty
  property p_rdata; !$past(reg_rd_in) |-> reg_rdata_out == 16'h0000; endproperty
  property p_vdet;
    int_rst_in && pin_rstn_in && $past(pin_rstn_in, 8) |-> $stable(vdet_en_out);
  endproperty

  a_vector: assert property (p_vector) else $error("vector fetch order wrong");
  a_release: assert property (p_release) else $error("core released early");
  a_hold: assert property (p_hold) else $error("core not held in reset");
  a_sp: assert property (p_sp) else $error("stack pointer wrong");
  a_pc: assert property (p_pc) else $error("program counter wrong");
  a_zero: assert property (p_zero) else $error("interrupt state not zero");
  a_osc: assert property (p_osc) else $error("reset controls wrong");
  a_run: assert property (p_run) else $error("run controls wrong");
  a_rdata: assert property (p_rdata) else $error("read data stands too long");
  a_vdet: assert property (p_vdet) else $error("internal reset moved vdet");
endmodule // rwseq_properties

bind rwseq_top rwseq_properties u_props (
  .clk_in(clk_in), .rstn_in(rstn_in), .pin_rstn_in(pin_rstn_in),
  .int_rst_in(int_rst_in), .prom_mode_in(prom_mode_in), .reg_addr_in(reg_addr_in),
  .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
  .reg_rdata_out(reg_rdata_out), .trim_addr_out(trim_addr_out),
  .trim_data_in(trim_data_in), .trim_latch_out(trim_latch_out),
  .trim_data_abnormal_flag_out(trim_data_abnormal_flag_out), .core_out(core_out),
  .vector_addr_out(vector_addr_out), .vector_rd_out(vector_rd_out),
  .interrupt_enable_bits_out(interrupt_enable_bits_out),
  .interrupt_latches_out(interrupt_latches_out), .sys_out(sys_out),
  .vdet_en_out(vdet_en_out));

// ---- verification/rwseq_trim_model.sv ----
// Purpose: Behavioural trim store seen by the sequencer
// Assumes: Data follows the address in the same cycle
// Notes:   Word three makes the XOR of all words zero unless corrupted
`timescale 1ns/1ps
module rwseq_trim_model
  import rwseq_pkg::*;
#(
  parameter logic [7:0] WORD0 = 8'h5A
) (
  // Clock and fault control
  input  wire logic                    clk_in,
  input  wire logic                    corrupt_in,
  // Store port
  input  wire logic [RWSEQ_TADR_W-1:0] addr_in,
  output logic [RWSEQ_TRIM_W-1:0]      data_out
);
  logic [7:0] junk = 8'hA5;
  logic [7:0] words [4];

  // Unused addresses give a changing pattern, never a stale word
  always @(posedge clk_in) junk <= ~junk + 8'h01;

  // Corrupting word one breaks the checksum on purpose
  assign words[0] = WORD0;
  assign words[1] = corrupt_in ? 8'h3C : 8'hC3;
  assign words[2] = 8'h17;
  assign words[3] = WORD0 ^ 8'hC3 ^ 8'h17;
  assign data_out = (addr_in <= RWSEQ_TRIM_LAST) ? words[addr_in[1:0]] : junk;
endmodule // rwseq_trim_model

// ---- verification/testbench.sv ----
// Purpose: Self-checking bench for the reset and warm-up sequencer
// Assumes: 40 MHz clock, inputs driven by NBA at the rising edge
// Notes:   Model tracks limit, vdet and trim state to predict status
`timescale 1ns/1ps
module testbench;
  import rwseq_pkg::*;
  localparam logic [7:0] W0 = 8'h96;
  logic clk_in = 1'b0, rstn_in = 1'b0, pin_rstn_in = 1'b1, int_rst_in = 1'b0;
  logic prom_mode_in = 1'b0, reg_wr_in = 1'b0, reg_rd_in = 1'b0, corrupt = 1'b0;
  logic [3:0] reg_addr_in = 4'h0;
  logic [15:0] reg_wdata_in = 16'h0000, reg_rdata_out, vector_addr_out, rd;
  logic [2:0] trim_addr_out;
  logic [7:0] trim_data_in, trim_latch_out, ie_bits, il_bits;
  logic flag, vector_rd_out, vdet_en_out;
  rwseq_core_type core_out;
  rwseq_sys_type sys_out;
  int err_count = 0, n_tests = 0, cyc = 0, seed, lim, m_vdet = 0, m_bad = 0;
  logic [15:0] vq [$];

  always #12.5 clk_in = ~clk_in;

  rwseq_top u_dut (.clk_in(clk_in), .rstn_in(rstn_in), .pin_rstn_in(pin_rstn_in),
    .int_rst_in(int_rst_in), .prom_mode_in(prom_mode_in), .reg_addr_in(reg_addr_in),
    .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
    .reg_rdata_out(reg_rdata_out), .trim_addr_out(trim_addr_out),
    .trim_data_in(trim_data_in), .trim_latch_out(trim_latch_out),
    .trim_data_abnormal_flag_out(flag), .core_out(core_out),
    .vector_addr_out(vector_addr_out), .vector_rd_out(vector_rd_out),
    .interrupt_enable_bits_out(ie_bits), .interrupt_latches_out(il_bits),
    .sys_out(sys_out), .vdet_en_out(vdet_en_out));
  rwseq_trim_model #(.WORD0(W0)) u_store (.clk_in(clk_in), .corrupt_in(corrupt),
    .addr_in(trim_addr_out), .data_out(trim_data_in));

  // Vector fetch monitor feeds the model queue
  always @(posedge clk_in) if (vector_rd_out === 1'b1) vq.push_back(vector_addr_out);

  // Hang guard: well above the longest expected run
  always @(posedge clk_in) begin
    cyc++;
    if (cyc == 40000) begin
      err_count++;
      complete_run();
    end
  end

  task automatic complete_run();
    $display("counts: %0d compared, %0d mismatched", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_count++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk_in);
    reg_addr_in <= a; reg_wdata_in <= d; reg_wr_in <= 1'b1;
    @(posedge clk_in);
    reg_wr_in <= 1'b0;
  endtask

  task automatic rdr(input logic [3:0] a, output logic [15:0] d);
    @(posedge clk_in);
    reg_addr_in <= a; reg_rd_in <= 1'b1;
    @(posedge clk_in);
    reg_rd_in <= 1'b0;
    #1 d = reg_rdata_out;
  endtask

  // Wait for release after a source let go at the last edge
  task automatic seq_end(input int l, input string name);
    int n;
    n = 0;
    while (core_out.core_reset !== 1'b0 && n < 3000) begin
      @(posedge clk_in);
      #1 n++;
    end
    // High vector word is still on the bus as the core leaves reset
    repeat (2) @(posedge clk_in);
    chk({15'h0, n >= l && n <= l + 60}, 16'h0001);
    chk(16'(vq.size()), 16'h0002);
    if (vq.size() == 2) chk(vq[0], RWSEQ_VEC_LO);
    if (vq.size() == 2) chk(vq[1], RWSEQ_VEC_HI);
    vq.delete();
    chk({8'h00, trim_latch_out}, {8'h00, W0});
    chk({15'h0, flag}, 16'(m_bad));
    rdr(RWSEQ_REG_STATUS, rd);
    chk(rd, 16'(m_vdet * 8 + m_bad * 4 + 1));
    $display("test %s done", name);
  endtask

  task automatic pin_low();
    @(posedge clk_in) pin_rstn_in <= 1'b0;
    repeat (200 + ($random(seed) & 63)) @(posedge clk_in);
  endtask

  initial begin
    seed = 32'h0fc38c35;
    repeat (10) @(posedge clk_in);
    rstn_in <= 1'b1;
    seq_end(16'h0400, "power-on");
    rdr(RWSEQ_REG_TRIM, rd);
    chk(rd, {8'h00, W0});
    rdr(RWSEQ_REG_CAUSE, rd);
    chk(rd, 16'h0001);
    // Registers: random short limit, vdet on, unmapped place
    lim = 16 + ($random(seed) & 15);
    wr(RWSEQ_REG_WARMUP, lim[15:0]);
    wr(RWSEQ_REG_CTRL, 16'h0002);
    wr(4'hF, 16'hFFFF);
    rdr(4'hF, rd);
    chk(rd, 16'h0000);
    rdr(RWSEQ_REG_WARMUP, rd);
    chk(rd, lim[15:0]);
    m_vdet = 1;
    // Internal reset keeps vdet and the short limit
    @(posedge clk_in) int_rst_in <= 1'b1;
    repeat (8) @(posedge clk_in);
    int_rst_in <= 1'b0;
    seq_end(lim, "internal");
    chk({15'h0, vdet_en_out}, 16'h0001);
    rdr(RWSEQ_REG_CAUSE, rd);
    chk(rd, 16'h0005);
    // Pin reset, then a second one in mid warm-up
    pin_low();
    rdr(RWSEQ_REG_CORE, rd);
    chk(rd, 16'h0000);
    @(posedge clk_in) pin_rstn_in <= 1'b1;
    repeat (30) @(posedge clk_in);
    pin_low();
    pin_rstn_in <= 1'b1;
    m_vdet = 0;
    seq_end(16'h0400, "pin restart");
    chk({15'h0, vdet_en_out}, 16'h0000);
    // Bad trim seen after an internal reload
    @(posedge clk_in) corrupt <= 1'b1;
    int_rst_in <= 1'b1;
    repeat (8) @(posedge clk_in);
    int_rst_in <= 1'b0;
    m_bad = 1;
    seq_end(16'h0400, "bad trim");
    corrupt <= 1'b0;
    // Serial PROM mode program counter in warm-up
    @(posedge clk_in) rstn_in <= 1'b0;
    prom_mode_in <= 1'b1;
    repeat (3) @(posedge clk_in);
    rstn_in <= 1'b1;
    m_bad = 0;
    repeat (4) @(posedge clk_in);
    #1 chk(core_out.program_counter, RWSEQ_PC_PROM);
    @(posedge clk_in);
    seq_end(16'h0400 - 5, "prom");
    complete_run();
  end
endmodule // testbench
